// ==== core/pm_vector_ref_defines.svh ====
/*
  Address map, vector field layout and slot positions of the program-memory
  vector and table-reference block.
  Assumes a 14-bit byte address into a 16 KB program ROM.
*/
`ifndef PM_VECTOR_REF_DEFINES_SVH
`define PM_VECTOR_REF_DEFINES_SVH

// ==========================================================================
// program memory map
`define ROM_ADDR_W 14
`define ROM_LAST 14'h3fff
`define VEC_AREA_BASE 14'h0000
`define VEC_AREA_LAST 14'h000d
`define GP_LOW_BASE 14'h000e
`define GP_LOW_LAST 14'h001f
`define REF_BASE 14'h0020
`define REF_LAST 14'h007f
`define GP_HIGH_BASE 14'h0080
`define REF_ENTRIES 6'h30

// ==========================================================================
// vector entry first byte
`define VEC_MBE_BIT 7
`define VEC_RBE_BIT 6
`define VEC_ZERO_BIT 5
`define VEC_PCHI_MSB 4

// ==========================================================================
// vector slots, two bytes each from address zero
`define SLOT_RESET 3'h0
`define SLOT_SECOND 3'h1
`define SLOT_EXT_ZERO 3'h2
`define SLOT_EXT_ONE 3'h3
`define SLOT_FIFTH 3'h4
`define SLOT_TIMER_ZERO 3'h5
`define SLOT_TIMER_ONE 3'h6

// ==========================================================================
// reset values
`define MBE_RESET 1'h0
`define RBE_RESET 1'h0

`endif

// ==== core/pm_vector_ref_pkg.sv ====
/*
  Types of the program-memory vector and table-reference block.
  Assumes the defines header is included by the design file.
*/
package pm_vector_ref_pkg;

  // ========================================================================
  // enumerations
  typedef enum logic [2:0] {
    IDLE,
    READ_FIRST,
    READ_SECOND,
    FINISH
  } fetch_state_type;

  typedef enum logic [1:0] {
    AREA_VECTOR,
    AREA_GP_LOW,
    AREA_REF_TABLE,
    AREA_GP_HIGH
  } rom_area_type;

  typedef enum logic [1:0] {
    REF_PLAIN,
    REF_TABLE_JUMP,
    REF_TABLE_CALL
  } ref_kind_type;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic rd;
    logic [13:0] addr;
  } rom_req_type;

  typedef struct packed {
    logic [13:0] pcValue;
    logic pcLoad;
    rom_area_type pcArea;
  } pc_out_type;

  typedef struct packed {
    logic refDone;
    ref_kind_type refKind;
    logic [15:0] refInstr;
  } ref_out_type;

  typedef struct packed {
    fetch_state_type state;
    logic isVec;
    logic [7:0] firstByte;
    rom_req_type rom;
    pc_out_type pc;
    ref_out_type refRes;
    logic memBankEnable;
    logic regBankEnable;
    logic flagsLoad;
    logic busy;
  } state_type;

endpackage : pm_vector_ref_pkg

// ==== core/program_memory_vector_ref.sv ====
/*
  Program-memory side of a 4-bit core: vector fetch for reset and the
  interrupt sources, and the two-byte table-reference fetch.
  Assumes a synchronous ROM: data for an address presented with rd high
  appears on romData in the following cycle.
*/
`timescale 1ns/10ps
`include "pm_vector_ref_defines.svh"

// Notes on behaviour
// - counter reaches all 16384 bytes directly
// - bottom 14 bytes hold reset/interrupt vectors
// - vector fetch loads both bank enable flags
// - byte one: flags, zero, PC12..8; byte two
// - slots two bytes apart, reset first
// - fetch by slot position, content unchecked
// - 0020H..007FH is the look-up table
// - entry runs as two-byte, two one-byte, jump/call
// - table jump/call forms reach any location
// - other areas are general-purpose memory
module program_memory_vector_ref
  import pm_vector_ref_pkg::*;
#(
  parameter logic [1:0] TABLE_JUMP_PREFIX = 2'h2,
  parameter logic [1:0] TABLE_CALL_PREFIX = 2'h3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // vector request from interrupt logic
  input wire logic vecReq,
  input wire logic [2:0] vecSlot,
  // table-reference request from the decoder
  input wire logic refReq,
  input wire logic [5:0] refIndex,
  // program ROM
  output rom_req_type romReq,
  input wire logic [7:0] romData,
  // results
  output pc_out_type pcOut,
  output ref_out_type refOut,
  output logic memBankEnable,
  output logic regBankEnable,
  output logic flagsLoad,
  output logic busy
);

  // ========================================================================
  // helpers
  function automatic rom_area_type areaOf(input logic [13:0] a);
    if (a <= `VEC_AREA_LAST) begin
      areaOf = AREA_VECTOR;
    end else if (a <= `GP_LOW_LAST) begin
      areaOf = AREA_GP_LOW;
    end else if (a <= `REF_LAST) begin
      areaOf = AREA_REF_TABLE;
    end else begin
      areaOf = AREA_GP_HIGH;
    end
  endfunction : areaOf

  localparam state_type RESET_STATE = '{
    state: READ_FIRST,
    isVec: 1'b1,
    firstByte: 8'h00,
    rom: '{rd: 1'b1, addr: `VEC_AREA_BASE},
    pc: '{pcValue: 14'h0000, pcLoad: 1'b0, pcArea: AREA_VECTOR},
    refRes: '{refDone: 1'b0, refKind: REF_PLAIN, refInstr: 16'h0000},
    memBankEnable: `MBE_RESET,
    regBankEnable: `RBE_RESET,
    flagsLoad: 1'b0,
    busy: 1'b1
  };

  state_type q_ff;
  state_type nxt_q;

  // ========================================================================
  // fetch sequencer
  always_comb begin
    nxt_q = q_ff;
    nxt_q.pc.pcLoad = 1'b0;
    nxt_q.refRes.refDone = 1'b0;
    nxt_q.flagsLoad = 1'b0;
    case (q_ff.state)
      IDLE: begin
        // vectors win over a table reference in the same cycle
        if (vecReq && vecSlot <= `SLOT_TIMER_ONE) begin
          nxt_q.rom.addr = {10'h000, vecSlot, 1'b0};
          nxt_q.rom.rd = 1'b1;
          nxt_q.isVec = 1'b1;
          nxt_q.state = READ_FIRST;
        end else if (refReq && refIndex < `REF_ENTRIES) begin
          nxt_q.rom.addr = `REF_BASE + {7'h00, refIndex, 1'b0};
          nxt_q.rom.rd = 1'b1;
          nxt_q.isVec = 1'b0;
          nxt_q.state = READ_FIRST;
        end
      end
      READ_FIRST: begin
        nxt_q.rom.addr = q_ff.rom.addr + 14'h0001;
        nxt_q.state = READ_SECOND;
      end
      READ_SECOND: begin
        nxt_q.rom.rd = 1'b0;
        nxt_q.firstByte = romData;
        nxt_q.state = FINISH;
      end
      FINISH: begin
        nxt_q.state = IDLE;
        if (q_ff.isVec) begin
          // bit 5 of the first byte is ignored, not checked
          nxt_q.pc.pcValue = {1'b0, q_ff.firstByte[`VEC_PCHI_MSB:0], romData};
          nxt_q.pc.pcLoad = 1'b1;
          nxt_q.memBankEnable = q_ff.firstByte[`VEC_MBE_BIT];
          nxt_q.regBankEnable = q_ff.firstByte[`VEC_RBE_BIT];
          nxt_q.flagsLoad = 1'b1;
        end else begin
          nxt_q.refRes.refInstr = {q_ff.firstByte, romData};
          nxt_q.refRes.refDone = 1'b1;
          nxt_q.refRes.refKind = REF_PLAIN;
          if (q_ff.firstByte[7:6] == TABLE_JUMP_PREFIX) begin
            nxt_q.refRes.refKind = REF_TABLE_JUMP;
          end else if (q_ff.firstByte[7:6] == TABLE_CALL_PREFIX) begin
            nxt_q.refRes.refKind = REF_TABLE_CALL;
          end
          if (nxt_q.refRes.refKind != REF_PLAIN) begin
            // full 14-bit target: any program location
            nxt_q.pc.pcValue = {q_ff.firstByte[5:0], romData};
            nxt_q.pc.pcLoad = 1'b1;
          end
        end
      end
      default: begin
        nxt_q.state = IDLE;
        nxt_q.rom.rd = 1'b0;
      end
    endcase
    nxt_q.pc.pcArea = areaOf(nxt_q.pc.pcValue);
    nxt_q.busy = (nxt_q.state != IDLE);
  end

  // reset restarts at the reset slot with no idle cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_ff <= RESET_STATE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign romReq = q_ff.rom;
  assign pcOut = q_ff.pc;
  assign refOut = q_ff.refRes;
  assign memBankEnable = q_ff.memBankEnable;
  assign regBankEnable = q_ff.regBankEnable;
  assign flagsLoad = q_ff.flagsLoad;
  assign busy = q_ff.busy;

  // ========================================================================
  // checks
  property p_vec_slot_addr;
    @(posedge mclk) disable iff (rst)
    (!busy && vecReq && vecSlot <= 3'h6) |=> romReq.rd && romReq.addr == {10'h000, $past(vecSlot), 1'b0};
  endproperty
  a_vec_slot_addr: assert property (p_vec_slot_addr) else $error("vector slot address wrong");

  property p_vec_second_byte;
    @(posedge mclk) disable iff (rst)
    (q_ff.state == READ_FIRST) |=> romReq.rd && romReq.addr == $past(romReq.addr) + 14'h0001;
  endproperty
  a_vec_second_byte: assert property (p_vec_second_byte) else $error("second byte not next address");

  property p_vec_flags;
    @(posedge mclk) disable iff (rst)
    flagsLoad |-> memBankEnable == $past(romData[7], 2) && regBankEnable == $past(romData[6], 2)
      && pcOut.pcLoad;
  endproperty
  a_vec_flags: assert property (p_vec_flags) else $error("bank flags not from vector");

  property p_vec_pc;
    @(posedge mclk) disable iff (rst)
    flagsLoad |-> pcOut.pcValue == {1'b0, $past(romData[4:0], 2), $past(romData, 1)};
  endproperty
  a_vec_pc: assert property (p_vec_pc) else $error("vector address decode wrong");

  property p_vec_area;
    @(posedge mclk) disable iff (rst)
    (romReq.rd && q_ff.isVec) |-> romReq.addr <= 14'h000d;
  endproperty
  a_vec_area: assert property (p_vec_area) else $error("vector read outside vector area");

  property p_ref_addr;
    @(posedge mclk) disable iff (rst)
    (!busy && !vecReq && refReq && refIndex < 6'h30)
      |=> romReq.addr == 14'h0020 + {7'h00, $past(refIndex), 1'b0} ##1 romReq.rd ##1 !romReq.rd;
  endproperty
  a_ref_addr: assert property (p_ref_addr) else $error("table entry address wrong");

  property p_ref_area;
    @(posedge mclk) disable iff (rst)
    (romReq.rd && !q_ff.isVec) |-> romReq.addr >= 14'h0020 && romReq.addr <= 14'h007f;
  endproperty
  a_ref_area: assert property (p_ref_area) else $error("table read outside look-up area");

  property p_ref_jump;
    @(posedge mclk) disable iff (rst)
    (refOut.refDone && refOut.refKind != REF_PLAIN)
      |-> pcOut.pcLoad && pcOut.pcValue == {$past(romData[5:0], 2), $past(romData, 1)};
  endproperty
  a_ref_jump: assert property (p_ref_jump) else $error("table jump target wrong");

  property p_ref_instr;
    @(posedge mclk) disable iff (rst)
    refOut.refDone |-> refOut.refInstr == {$past(romData, 2), $past(romData, 1)} && !busy;
  endproperty
  a_ref_instr: assert property (p_ref_instr) else $error("table entry bytes wrong");

  property p_pc_area;
    @(posedge mclk) disable iff (rst)
    // area bounds written out, not taken from the decoder's own function
    pcOut.pcLoad |-> pcOut.pcArea == ((pcOut.pcValue <= 14'h000d) ? AREA_VECTOR :
      (pcOut.pcValue <= 14'h001f) ? AREA_GP_LOW : (pcOut.pcValue <= 14'h007f) ? AREA_REF_TABLE : AREA_GP_HIGH);
  endproperty
  a_pc_area: assert property (p_pc_area) else $error("program area classification wrong");

  property p_reset_vector;
    @(posedge mclk)
    $fell(rst) |-> romReq.rd && romReq.addr == 14'h0000 ##1 romReq.addr == 14'h0001 ##2 flagsLoad;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset vector not fetched");

endmodule : program_memory_vector_ref

// ==== sim/pm_rom_model.sv ====
/*
  Behavioural program ROM facing the vector and table-reference block.
  Assumes the bench preloads mem; data follows rd/addr by one cycle.
*/
`timescale 1ns/10ps
module pm_rom_model (
  // clock
  input wire logic mclk,
  // read port
  input wire logic rd,
  input wire logic [13:0] addr,
  output logic [7:0] data
);
  // ==========================================================================
  // storage
  logic [7:0] mem [0:16383];
  logic [7:0] data_ff = 8'ha5;

  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // no read: bus turns over every cycle, so a late sample never looks valid
  always_ff @(posedge mclk) begin
    if (rd) begin
      data_ff <= mem[addr];
    end else begin
      data_ff <= ~data_ff;
    end
  end
  assign data = data_ff;
endmodule : pm_rom_model

// ==== sim/program_memory_vector_ref_tb.sv ====
/*
  Self-checking bench of the vector and table-reference fetch block.
  Assumes the design package and the ROM model in pm_rom_model.sv.
*/
`timescale 1ns/10ps
module program_memory_vector_ref_tb import pm_vector_ref_pkg::*; ;
  // ==========================================================================
  // signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic vecReq = 1'b0;
  logic [2:0] vecSlot = 3'h0;
  logic refReq = 1'b0;
  logic [5:0] refIndex = 6'h00;
  logic [7:0] romData;
  rom_req_type romReq;
  pc_out_type pcOut;
  ref_out_type refOut;
  logic memBankEnable;
  logic regBankEnable;
  logic flagsLoad;
  logic busy;
  int failures = 0;
  int totalChecks = 0;
  int cycles = 0;
  int lat;
  logic [13:0] firstAddr;
  logic [7:0] vecHi [7] = '{8'hc1, 8'h00, 8'h40, 8'h80, 8'hf2, 8'h1f, 8'h00};
  logic [7:0] vecLo [7] = '{8'h23, 8'h05, 8'h10, 8'h40, 8'hab, 8'hff, 8'h80};
  logic [5:0] refN [4] = '{6'h00, 6'h01, 6'h02, 6'h2f};
  logic [15:0] refWord [4] = '{16'h1234, 16'h8100, 16'hc01a, 16'h3c5d};

  program_memory_vector_ref program_memory_vector_ref_i (.mclk(mclk), .rst(rst), .vecReq(vecReq),
    .vecSlot(vecSlot), .refReq(refReq), .refIndex(refIndex), .romReq(romReq), .romData(romData),
    .pcOut(pcOut), .refOut(refOut), .memBankEnable(memBankEnable), .regBankEnable(regBankEnable),
    .flagsLoad(flagsLoad), .busy(busy));
  pm_rom_model pm_rom_model_i (.mclk(mclk), .rd(romReq.rd), .addr(romReq.addr), .data(romData));

  // ==========================================================================
  // helpers
  function automatic logic [1:0] areaOf(input logic [13:0] a);
    if (a <= 14'h000d) return 2'h0;
    if (a <= 14'h001f) return 2'h1;
    if (a <= 14'h007f) return 2'h2;
    return 2'h3;
  endfunction : areaOf

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // bounded: a missing answer must not hang the run
  task automatic wait_pulse(output logic hit);
    hit = 1'b0;
    lat = 6;
    for (int i = 0; i < 6 && !hit; i++) begin
      if (flagsLoad === 1'b1 || refOut.refDone === 1'b1) begin
        hit = 1'b1;
        lat = i;
      end else begin
        @(negedge mclk);
      end
    end
  endtask : wait_pulse

  task automatic issue(input logic isVec, input logic [5:0] sel, output logic hit);
    vecReq = isVec;
    refReq = ~isVec;
    vecSlot = sel[2:0];
    refIndex = sel;
    @(negedge mclk);
    firstAddr = romReq.addr;
    vecReq = 1'b0;
    refReq = 1'b0;
    wait_pulse(hit);
  endtask : issue

  task automatic chk_vec(input int s);
    logic [13:0] pc;
    pc = {1'b0, vecHi[s][4:0], vecLo[s]};
    chk(16'(lat), 16'h3, "answer latency");
    chk(16'(pcOut.pcValue), 16'(pc), "vector target");
    chk(16'(pcOut.pcArea), 16'(areaOf(pc)), "target area");
    chk(16'({memBankEnable, regBankEnable, pcOut.pcLoad}), 16'({vecHi[s][7:6], 1'b1}), "flags");
  endtask : chk_vec

  // ==========================================================================
  // scenarios
  task automatic test_reset();
    logic hit;
    chk(16'({busy, romReq.rd, romReq.addr}), 16'hc000, "reset fetch at zero");
    rst = 1'b0;
    wait_pulse(hit);
    chk_vec(0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_vectors();
    logic hit;
    for (int s = 1; s < 7; s++) begin
      issue(1'b1, 6'(s), hit);
      chk(16'(firstAddr), 16'(2 * s), "slot address");
      chk_vec(s);
    end
    $display("test_vectors done");
  endtask : test_vectors

  task automatic test_refs();
    logic hit;
    logic [15:0] w;
    logic [1:0] kind;
    for (int k = 0; k < 4; k++) begin
      w = refWord[k];
      kind = (w[15:14] == 2'h2) ? 2'h1 : (w[15:14] == 2'h3) ? 2'h2 : 2'h0;
      issue(1'b0, refN[k], hit);
      chk(16'(lat), 16'h3, "answer latency");
      chk(16'(firstAddr), 16'h0020 + 16'(refN[k]) * 16'h2, "entry address");
      chk(refOut.refInstr, w, "entry bytes");
      chk(16'({refOut.refKind, pcOut.pcLoad}), 16'({kind, kind != 2'h0}), "entry kind");
      if (kind != 2'h0) begin
        chk(16'(pcOut.pcValue), 16'(w[13:0]), "branch target");
      end
    end
    $display("test_refs done");
  endtask : test_refs

  task automatic test_refused();
    logic hit;
    issue(1'b1, 6'h07, hit);
    chk(16'({hit, busy}), 16'h0, "slot seven");
    issue(1'b0, 6'h30, hit);
    chk(16'({hit, busy}), 16'h0, "index past table");
    vecReq = 1'b1;
    vecSlot = 3'h2;
    @(negedge mclk);
    vecReq = 1'b0;
    // a valid entry, so only busy can make the design ignore it
    refIndex = 6'h01;
    refReq = 1'b1;
    @(negedge mclk);
    refReq = 1'b0;
    wait_pulse(hit);
    chk(16'(pcOut.pcValue), 16'h0010, "vector while busy");
    @(negedge mclk);
    wait_pulse(hit);
    chk(16'(hit), 16'h0, "request while busy");
    $display("test_refused done");
  endtask : test_refused

  task automatic close_out();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // clock, timeout, sequence
  initial begin
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    // let the model lay down its fill pattern first, then overlay the image
    #1;
    for (int s = 0; s < 7; s++) begin
      pm_rom_model_i.mem[2 * s] = vecHi[s];
      pm_rom_model_i.mem[2 * s + 1] = vecLo[s];
    end
    for (int k = 0; k < 4; k++) begin
      pm_rom_model_i.mem[32 + 2 * refN[k]] = refWord[k][15:8];
      pm_rom_model_i.mem[33 + 2 * refN[k]] = refWord[k][7:0];
    end
    repeat (5) @(negedge mclk);
    test_reset();
    test_vectors();
    test_refs();
    test_refused();
    close_out();
  end
endmodule : program_memory_vector_ref_tb
